// [dcc_pkg.sv]
// Constants, encodings and types shared by the DMA channel control block.
// Assumes one 100 MHz clock, an asynchronous active-low reset, and no register bus.
package dcc_pkg;
    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_CH = 32;
    localparam int CH_W = 5;
    localparam int ITEM_W = 10;
    localparam int ARB_W = 4;
    localparam int BURST_W = 11;
    localparam int MODE_W = 3;
    localparam int XFER_W = CH_W + 1 + ITEM_W;
    localparam logic [ARB_W-1:0] ARB_LOG2_MAX = 4'h0a;

    // ------------------------------------------------------------------
    // Transfer modes and structure select
    // ------------------------------------------------------------------
    localparam logic [MODE_W-1:0] TRANSFER_IDLE_MODE = 3'h0;
    localparam logic [MODE_W-1:0] REQUEST_DRIVEN_MODE = 3'h1;
    localparam logic [MODE_W-1:0] RUN_TO_COMPLETION_MODE = 3'h2;
    localparam logic [MODE_W-1:0] DOUBLE_BUFFER_MODE = 3'h3;
    localparam logic [MODE_W-1:0] MEMORY_LIST_MODE = 3'h4;
    localparam logic [MODE_W-1:0] PERIPHERAL_LIST_MODE = 3'h5;
    localparam logic PRIMARY_STRUCT_SEL = 1'b0;
    localparam logic ALTERNATE_STRUCT_SEL = 1'b1;

    // ------------------------------------------------------------------
    // Channel numbers (default assignment; secondary shares the number)
    // ------------------------------------------------------------------
    localparam logic [CH_W-1:0] ASYNC_SER0_RX_CH = 5'h08;
    localparam logic [CH_W-1:0] ASYNC_SER0_TX_CH = 5'h09;
    localparam logic [CH_W-1:0] SYNC_SER0_RX_CH = 5'h0a;
    localparam logic [CH_W-1:0] SYNC_SER0_TX_CH = 5'h0b;
    localparam logic [CH_W-1:0] CONV_SEQ0_CH = 5'h0e;
    localparam logic [CH_W-1:0] CONV_SEQ1_CH = 5'h0f;
    localparam logic [CH_W-1:0] CONV_SEQ2_CH = 5'h10;
    localparam logic [CH_W-1:0] CONV_SEQ3_CH = 5'h11;
    localparam logic [CH_W-1:0] TIMER0_A_CH = 5'h12;
    localparam logic [CH_W-1:0] TIMER0_B_CH = 5'h13;
    localparam logic [CH_W-1:0] TIMER1_A_CH = 5'h14;
    localparam logic [CH_W-1:0] TIMER1_B_CH = 5'h15;
    localparam logic [CH_W-1:0] ASYNC_SER1_RX_CH = 5'h16;
    localparam logic [CH_W-1:0] ASYNC_SER1_TX_CH = 5'h17;
    localparam logic [CH_W-1:0] SYNC_SER1_RX_CH = 5'h18;
    localparam logic [CH_W-1:0] SYNC_SER1_TX_CH = 5'h19;
    localparam logic [CH_W-1:0] AUDIO_RX_CH = 5'h1c;
    localparam logic [CH_W-1:0] AUDIO_TX_CH = 5'h1d;
    localparam logic [CH_W-1:0] SOFTWARE_ONLY_CHANNEL = 5'h1e;
    localparam logic [CH_W-1:0] SOFTWARE_ONLY_CHANNEL_SECONDARY = 5'h1e;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [NUM_CH-1:0] ENABLE_RST = 32'h0000_0000;
    localparam logic [ITEM_W-1:0] ITEMS_RST = 10'h000;

    typedef enum logic {DCC_ENG_IDLE, DCC_ENG_RUN} dcc_eng_state_t;
endpackage : dcc_pkg

// [dcc_skid_buf.sv]
// Two-entry buffer with valid and ready on both sides and registered outputs.
// Assumes the filling side holds its word while ready is low.
`timescale 1ns/100ps
module dcc_skid_buf #(
    parameter int W = dcc_pkg::XFER_W
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic i_in_valid,
    input wire logic [W-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [W-1:0] o_out_data,
    input wire logic i_out_ready
);
    logic skid_valid;
    logic [W-1:0] skid_data;
    logic next_out_valid;
    logic [W-1:0] next_out_data;
    logic next_skid_valid;
    logic [W-1:0] next_skid_data;
    logic push;

    // Ready is a flop: the second entry absorbs the word in flight when the drain stalls.
    assign o_in_ready = ~skid_valid;
    assign push = i_in_valid & ~skid_valid;

    always_comb begin
        next_out_valid = o_out_valid;
        next_out_data = o_out_data;
        next_skid_valid = skid_valid;
        next_skid_data = skid_data;
        if (!o_out_valid || i_out_ready) begin
            if (skid_valid) begin
                next_out_data = skid_data;
                next_skid_valid = 1'b0;
            end else begin
                next_out_valid = push;
                next_out_data = push ? i_in_data : o_out_data;
            end
        end else if (push) begin
            next_skid_valid = 1'b1;
            next_skid_data = i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_out_valid <= 1'b0;
            o_out_data <= '0;
            skid_valid <= 1'b0;
            skid_data <= '0;
        end else if (i_ce) begin
            o_out_valid <= next_out_valid;
            o_out_data <= next_out_data;
            skid_valid <= next_skid_valid;
            skid_data <= next_skid_data;
        end
    end
endmodule : dcc_skid_buf

// [dcc_channel_ctrl.sv]
// Per-channel enable, mode table, request arbitration and item issue of the DMA controller.
// Assumes peripheral requests are synchronous levels and software strobes are one-cycle pulses.
`timescale 1ns/100ps
module dcc_channel_ctrl (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic [dcc_pkg::NUM_CH-1:0] i_en_set,
    input wire logic [dcc_pkg::NUM_CH-1:0] i_en_clr,
    input wire logic [dcc_pkg::NUM_CH-1:0] i_sw_req,
    input wire logic [dcc_pkg::NUM_CH-1:0] i_request_block_attr,
    input wire logic [dcc_pkg::NUM_CH-1:0] i_use_secondary,
    input wire logic [dcc_pkg::NUM_CH-1:0] i_periph_req,
    input wire logic [dcc_pkg::NUM_CH-1:0] i_periph_req_sec,
    input wire logic i_cfg_wr,
    input wire logic [dcc_pkg::CH_W-1:0] i_cfg_ch,
    input wire logic i_cfg_alt,
    input wire logic [dcc_pkg::MODE_W-1:0] i_cfg_mode,
    input wire logic [dcc_pkg::ITEM_W-1:0] i_cfg_items_m1,
    input wire logic [dcc_pkg::ARB_W-1:0] i_arb_log2,
    input wire logic [dcc_pkg::CH_W-1:0] i_query_ch,
    input wire logic i_query_alt,
    input wire logic i_xfer_ready,
    output logic [dcc_pkg::NUM_CH-1:0] o_enabled,
    output logic [dcc_pkg::MODE_W-1:0] o_query_mode,
    output logic o_done_sw,
    output logic [dcc_pkg::NUM_CH-1:0] o_done_periph,
    output logic o_xfer_valid,
    output logic [dcc_pkg::CH_W-1:0] o_xfer_ch,
    output logic o_xfer_alt,
    output logic [dcc_pkg::ITEM_W-1:0] o_xfer_idx
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [dcc_pkg::NUM_CH-1:0] sw_pend, alt_act, hw_req, live, pend;
    logic [dcc_pkg::MODE_W-1:0] mode [dcc_pkg::NUM_CH][2];
    logic [dcc_pkg::ITEM_W-1:0] left [dcc_pkg::NUM_CH][2];
    dcc_pkg::dcc_eng_state_t state, next_state;
    logic [dcc_pkg::CH_W-1:0] cur_ch, next_cur_ch, pick;
    logic [dcc_pkg::BURST_W-1:0] burst, next_burst, arb_items;
    logic by_sw, next_by_sw, any_pend, push, complete, cont, go, act, buf_ready;
    logic [dcc_pkg::NUM_CH-1:0] next_en, next_sw_pend, next_alt_act, hw_clr, next_done_periph;
    logic [dcc_pkg::MODE_W-1:0] next_mode [dcc_pkg::NUM_CH][2];
    logic [dcc_pkg::ITEM_W-1:0] next_left [dcc_pkg::NUM_CH][2];
    logic [dcc_pkg::MODE_W-1:0] next_query, cur_mode;
    logic next_done_sw;
    logic [dcc_pkg::XFER_W-1:0] buf_out;

    // ------------------------------------------------------------------
    // Per-channel request qualification
    // ------------------------------------------------------------------
    for (genvar g = 0; g < dcc_pkg::NUM_CH; g++) begin : g_ch
        assign hw_req[g] = (i_use_secondary[g] ? i_periph_req_sec[g] : i_periph_req[g])
                           & ~i_request_block_attr[g];
        assign live[g] = mode[g][alt_act[g]] != dcc_pkg::TRANSFER_IDLE_MODE;
        assign pend[g] = o_enabled[g] & live[g] & (hw_req[g] | sw_pend[g]);
    end

    assign act = alt_act[cur_ch];
    assign cur_mode = mode[cur_ch][act];
    assign arb_items = (i_arb_log2 > dcc_pkg::ARB_LOG2_MAX) ? 11'h400 : 11'h001 << i_arb_log2;

    always_comb begin
        any_pend = 1'b0;
        pick = '0;
        for (int k = dcc_pkg::NUM_CH - 1; k >= 0; k--) begin
            if (pend[k]) begin
                any_pend = 1'b1;
                pick = dcc_pkg::CH_W'(k);
            end
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cur_ch = cur_ch;
        next_burst = burst;
        next_by_sw = by_sw;
        next_mode = mode;
        next_left = left;
        next_alt_act = alt_act;
        next_sw_pend = (sw_pend | i_sw_req) & o_enabled;
        hw_clr = '0;
        next_done_sw = 1'b0;
        next_done_periph = '0;
        push = 1'b0;
        complete = 1'b0;
        cont = 1'b0;
        go = 1'b0;
        unique case (state)
            dcc_pkg::DCC_ENG_IDLE: begin
                if (any_pend) begin
                    next_state = dcc_pkg::DCC_ENG_RUN;
                    next_cur_ch = pick;
                    next_burst = '0;
                    next_by_sw = sw_pend[pick];
                    next_sw_pend[pick] = i_sw_req[pick] & o_enabled[pick];
                end
            end
            dcc_pkg::DCC_ENG_RUN: begin
                // A software start runs its burst with no peripheral involved, as memory-to-memory needs.
                go = by_sw | (cur_mode == dcc_pkg::RUN_TO_COMPLETION_MODE)
                     | (cur_mode == dcc_pkg::MEMORY_LIST_MODE) | hw_req[cur_ch];
                if (!o_enabled[cur_ch] || cur_mode == dcc_pkg::TRANSFER_IDLE_MODE || !go) begin
                    next_state = dcc_pkg::DCC_ENG_IDLE;
                end else if (buf_ready) begin
                    push = 1'b1;
                    if (left[cur_ch][act] == '0) begin
                        complete = 1'b1;
                        next_state = dcc_pkg::DCC_ENG_IDLE;
                        next_mode[cur_ch][act] = dcc_pkg::TRANSFER_IDLE_MODE;
                        cont = cur_mode == dcc_pkg::DOUBLE_BUFFER_MODE
                               && mode[cur_ch][~act] != dcc_pkg::TRANSFER_IDLE_MODE;
                        if (cont) begin
                            next_alt_act[cur_ch] = ~act;
                        end else begin
                            hw_clr[cur_ch] = 1'b1;
                        end
                        if (cur_ch == dcc_pkg::SOFTWARE_ONLY_CHANNEL) begin
                            next_done_sw = 1'b1;
                        end else begin
                            next_done_periph[cur_ch] = 1'b1;
                        end
                    end else begin
                        next_left[cur_ch][act] = left[cur_ch][act] - 10'h001;
                        next_burst = burst + 11'h001;
                        if (next_burst >= arb_items) begin
                            next_state = dcc_pkg::DCC_ENG_IDLE;
                            // Re-arm the channel so a burst cut by re-arbitration resumes without a new request.
                            if (by_sw || cur_mode == dcc_pkg::RUN_TO_COMPLETION_MODE
                                || cur_mode == dcc_pkg::MEMORY_LIST_MODE) begin
                                next_sw_pend[cur_ch] = 1'b1;
                            end
                        end
                    end
                end
            end
        endcase
        // A software write to the table wins over the engine's update of the same entry.
        if (i_cfg_wr) begin
            next_mode[i_cfg_ch][i_cfg_alt] = i_cfg_mode;
            next_left[i_cfg_ch][i_cfg_alt] = i_cfg_items_m1;
        end
        // Software enable wins over both clears arriving in the same cycle.
        next_en = (o_enabled & ~i_en_clr & ~hw_clr) | i_en_set;
        next_query = mode[i_query_ch][i_query_alt];
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= dcc_pkg::DCC_ENG_IDLE;
            cur_ch <= '0;
            burst <= '0;
            by_sw <= 1'b0;
            o_enabled <= dcc_pkg::ENABLE_RST;
            sw_pend <= '0;
            alt_act <= '0;
            o_query_mode <= dcc_pkg::TRANSFER_IDLE_MODE;
            o_done_sw <= 1'b0;
            o_done_periph <= '0;
            for (int k = 0; k < dcc_pkg::NUM_CH; k++) begin
                for (int s = 0; s < 2; s++) begin
                    mode[k][s] <= dcc_pkg::TRANSFER_IDLE_MODE;
                    left[k][s] <= dcc_pkg::ITEMS_RST;
                end
            end
        end else if (i_ce) begin
            state <= next_state;
            cur_ch <= next_cur_ch;
            burst <= next_burst;
            by_sw <= next_by_sw;
            o_enabled <= next_en;
            sw_pend <= next_sw_pend;
            alt_act <= next_alt_act;
            o_query_mode <= next_query;
            o_done_sw <= next_done_sw;
            o_done_periph <= next_done_periph;
            mode <= next_mode;
            left <= next_left;
        end
    end

    dcc_skid_buf #(.W(dcc_pkg::XFER_W)) u_buf (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_in_valid(push),
        .i_in_data({cur_ch, act, left[cur_ch][act]}),
        .o_in_ready(buf_ready),
        .o_out_valid(o_xfer_valid),
        .o_out_data(buf_out),
        .i_out_ready(i_xfer_ready)
    );
    assign {o_xfer_ch, o_xfer_alt, o_xfer_idx} = buf_out;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_no_push_disabled;
        @(posedge i_clk) disable iff (!i_arst_n) push |-> o_enabled[cur_ch] && state == dcc_pkg::DCC_ENG_RUN;
    endproperty
    a_no_push_disabled: assert property (p_no_push_disabled) else $error("item issued on disabled channel");
    property p_done_clears;
        @(posedge i_clk) disable iff (!i_arst_n)
        complete && !cont && i_ce && !i_en_set[cur_ch] |=> !o_enabled[$past(cur_ch)];
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("enable kept after completion");
    property p_done_stop;
        @(posedge i_clk) disable iff (!i_arst_n) complete && i_ce && !i_cfg_wr
        |=> mode[$past(cur_ch)][$past(act)] == dcc_pkg::TRANSFER_IDLE_MODE;
    endproperty
    a_done_stop: assert property (p_done_stop) else $error("mode not idle after completion");
    property p_mode_legal;
        @(posedge i_clk) disable iff (!i_arst_n) o_query_mode <= dcc_pkg::PERIPHERAL_LIST_MODE || i_cfg_wr
        || $past(i_cfg_wr, 2);
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("illegal mode reported");
    property p_sw_line;
        @(posedge i_clk) disable iff (!i_arst_n) complete && i_ce && cur_ch == dcc_pkg::SOFTWARE_ONLY_CHANNEL
        |=> o_done_sw && o_done_periph == '0;
    endproperty
    a_sw_line: assert property (p_sw_line) else $error("software completion on wrong line");
    property p_periph_line;
        @(posedge i_clk) disable iff (!i_arst_n) complete && i_ce && cur_ch != dcc_pkg::SOFTWARE_ONLY_CHANNEL
        |=> o_done_periph[$past(cur_ch)] && !o_done_sw;
    endproperty
    a_periph_line: assert property (p_periph_line) else $error("peripheral completion on wrong line");
    property p_auto_runs;
        @(posedge i_clk) disable iff (!i_arst_n) state == dcc_pkg::DCC_ENG_RUN && o_enabled[cur_ch]
        && cur_mode == dcc_pkg::RUN_TO_COMPLETION_MODE && buf_ready |-> push;
    endproperty
    a_auto_runs: assert property (p_auto_runs) else $error("run-to-completion stalled");
    property p_block_req;
        @(posedge i_clk) disable iff (!i_arst_n) state == dcc_pkg::DCC_ENG_IDLE && any_pend
        |-> sw_pend[pick] || (i_use_secondary[pick] ? i_periph_req_sec[pick] : i_periph_req[pick])
        && !i_request_block_attr[pick];
    endproperty
    a_block_req: assert property (p_block_req) else $error("blocked request started channel");
    property p_burst_cap;
        @(posedge i_clk) disable iff (!i_arst_n) state == dcc_pkg::DCC_ENG_RUN |-> burst < arb_items;
    endproperty
    a_burst_cap: assert property (p_burst_cap) else $error("burst passed arbitration size");
    c_pingpong: cover property (@(posedge i_clk) disable iff (!i_arst_n) complete && cont);
    c_sw_done: cover property (@(posedge i_clk) disable iff (!i_arst_n) o_done_sw);
    c_stall: cover property (@(posedge i_clk) disable iff (!i_arst_n) o_xfer_valid && !i_xfer_ready && !buf_ready);
endmodule : dcc_channel_ctrl

// [dcc_far_model.sv]
// Far side of the item stream: a memory sink with an optional stall pattern,
// plus the interrupt receivers that latch completion pulses.
// Assumes the block's item stream and completion pulses are single-clock.
`timescale 1ns/100ps
module dcc_far_model (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_slow,
    input wire logic i_clear,
    input wire logic i_valid,
    input wire logic [dcc_pkg::CH_W-1:0] i_ch,
    input wire logic i_alt,
    input wire logic [dcc_pkg::ITEM_W-1:0] i_idx,
    input wire logic i_done_sw,
    input wire logic [dcc_pkg::NUM_CH-1:0] i_done_periph,
    output logic o_ready
);
    logic [dcc_pkg::XFER_W-1:0] words[$];
    logic done_sw_seen;
    logic [dcc_pkg::NUM_CH-1:0] done_periph_seen;
    logic [1:0] phase;
    // A slow sink accepts one word in four, so the two-entry buffer fills.
    assign o_ready = !i_slow || (phase == 2'h3);
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase <= 2'h0;
            done_sw_seen <= 1'b0;
            done_periph_seen <= '0;
            words.delete();
        end else begin
            phase <= phase + 2'h1;
            if (i_valid && o_ready) begin
                words.push_back({i_ch, i_alt, i_idx});
            end
            done_sw_seen <= !i_clear && (done_sw_seen || i_done_sw);
            done_periph_seen <= i_clear ? '0 : (done_periph_seen | i_done_periph);
        end
    end
endmodule : dcc_far_model

// [dcc_channel_ctrl_bench.sv]
// Self-checking bench of the channel control block with a stalling sink.
// Assumes the sink model of dcc_far_model and inputs driven 1 ns after the edge.
`timescale 1ns/100ps
module dcc_channel_ctrl_bench;
    logic i_clk = 0, i_arst_n = 0, i_ce = 1, i_cfg_wr = 0, i_cfg_alt = 0, i_query_alt = 0;
    logic slow = 0, clr = 0, xv, xa, xr, dsw;
    logic [31:0] i_en_set = 0, i_en_clr = 0, i_sw_req = 0, blk = 0, usec = 0, preq = 0, preq2 = 0, en, dp;
    logic [4:0] i_cfg_ch = 0, i_query_ch = 0, xc;
    logic [2:0] i_cfg_mode = 0, qm;
    logic [9:0] i_cfg_items_m1 = 0, xi;
    logic [3:0] arb = 4'h0a;
    int miscompares = 0, check_count = 0;
    dcc_channel_ctrl DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_en_set(i_en_set),
        .i_en_clr(i_en_clr), .i_sw_req(i_sw_req), .i_request_block_attr(blk), .i_use_secondary(usec),
        .i_periph_req(preq), .i_periph_req_sec(preq2), .i_cfg_wr(i_cfg_wr), .i_cfg_ch(i_cfg_ch),
        .i_cfg_alt(i_cfg_alt), .i_cfg_mode(i_cfg_mode), .i_cfg_items_m1(i_cfg_items_m1), .i_arb_log2(arb),
        .i_query_ch(i_query_ch), .i_query_alt(i_query_alt), .i_xfer_ready(xr), .o_enabled(en),
        .o_query_mode(qm), .o_done_sw(dsw), .o_done_periph(dp), .o_xfer_valid(xv), .o_xfer_ch(xc),
        .o_xfer_alt(xa), .o_xfer_idx(xi));
    dcc_far_model FAR (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_slow(slow), .i_clear(clr), .i_valid(xv),
        .i_ch(xc), .i_alt(xa), .i_idx(xi), .i_done_sw(dsw), .i_done_periph(dp), .o_ready(xr));
    initial forever #5 i_clk = ~i_clk;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    task automatic cfg(input logic [4:0] ch, input logic alt, input logic [2:0] m, input logic [9:0] n);
        {i_cfg_wr, i_cfg_ch, i_cfg_alt, i_cfg_mode, i_cfg_items_m1} = {1'b1, ch, alt, m, n};
        tick(1);
        i_cfg_wr = 0;
        tick(1);
    endtask : cfg
    task automatic pulse(input logic [4:0] ch, input int kind);
        if (kind == 0) i_en_set[ch] = 1;
        else if (kind == 1) i_sw_req[ch] = 1;
        else i_en_clr[ch] = 1;
        tick(1);
        {i_en_set, i_sw_req, i_en_clr} = '0;
        tick(1);
    endtask : pulse
    task automatic query(input logic [4:0] ch, input logic alt, input logic [2:0] exp);
        {i_query_ch, i_query_alt} = {ch, alt};
        tick(2);
        chk(32'(qm), 32'(exp));
    endtask : query
    // Waits for n words in the sink, then compares the oldest one.
    task automatic word(input int n, input logic [4:0] ch, input logic alt, input logic [9:0] idx);
        for (int k = 0; k < 300 && FAR.words.size() < n; k++) tick(1);
        chk(32'(FAR.words.size()), 32'(n));
        if (FAR.words.size() > 0) chk(32'(FAR.words.pop_front()), 32'({ch, alt, idx}));
    endtask : word
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_modes();
        for (int m = 0; m < 6; m++) begin
            cfg(5'h03, 1'b0, 3'(m), 10'h000);
            cfg(5'h03, 1'b1, 3'(5 - m), 10'h000);
            query(5'h03, 1'b0, 3'(m));
            query(5'h03, 1'b1, 3'(5 - m));
        end
        cfg(5'h03, 1'b0, dcc_pkg::TRANSFER_IDLE_MODE, 10'h000);
        cfg(5'h03, 1'b1, dcc_pkg::TRANSFER_IDLE_MODE, 10'h000);
    endtask : t_modes
    task automatic t_gate();
        cfg(5'h0c, 1'b0, dcc_pkg::REQUEST_DRIVEN_MODE, 10'h000);
        pulse(5'h0c, 1);
        preq[12] = 1;
        tick(10);
        chk(32'(FAR.words.size()), 32'h0000_0000);
        blk[12] = 1;
        pulse(5'h0c, 0);
        tick(10);
        chk(32'(FAR.words.size()), 32'h0000_0000);
        chk(32'(en[12]), 32'h0000_0001);
        blk[12] = 0;
        word(1, 5'h0c, 1'b0, 10'h000);
        preq[12] = 0;
        tick(3);
        chk(32'(en[12]), 32'h0000_0000);
        cfg(5'h0c, 1'b0, dcc_pkg::REQUEST_DRIVEN_MODE, 10'h000);
        pulse(5'h0c, 0);
        pulse(5'h0c, 2);
        preq[12] = 1;
        pulse(5'h0c, 1);
        tick(10);
        chk(32'(FAR.words.size()), 32'h0000_0000);
        preq[12] = 0;
    endtask : t_gate
    task automatic t_sw_stall();
        clr = 1;
        tick(1);
        clr = 0;
        slow = 1;
        cfg(5'h05, 1'b0, dcc_pkg::RUN_TO_COMPLETION_MODE, 10'h003);
        pulse(5'h05, 0);
        pulse(5'h05, 1);
        for (int k = 3; k >= 0; k--) word(1, 5'h05, 1'b0, 10'(k));
        slow = 0;
        tick(2);
        chk(32'(en[5]), 32'h0000_0000);
        query(5'h05, 1'b0, dcc_pkg::TRANSFER_IDLE_MODE);
        chk({30'h0, FAR.done_sw_seen, FAR.done_periph_seen[5]}, 32'h0000_0001);
    endtask : t_sw_stall
    task automatic t_hold();
        cfg(5'h09, 1'b0, dcc_pkg::RUN_TO_COMPLETION_MODE, 10'h002);
        pulse(5'h09, 0);
        preq[9] = 1;
        word(1, 5'h09, 1'b0, 10'h002);
        preq[9] = 0;
        word(1, 5'h09, 1'b0, 10'h001);
        word(1, 5'h09, 1'b0, 10'h000);
    endtask : t_hold
    task automatic t_rearb();
        arb = 4'h0;
        cfg(5'h07, 1'b0, dcc_pkg::REQUEST_DRIVEN_MODE, 10'h000);
        cfg(5'h08, 1'b0, dcc_pkg::RUN_TO_COMPLETION_MODE, 10'h002);
        pulse(5'h07, 0);
        pulse(5'h08, 0);
        pulse(5'h08, 1);
        // The lower channel asks during the first one-item burst, so it wins the next arbitration.
        preq[7] = 1;
        word(1, 5'h08, 1'b0, 10'h002);
        word(1, 5'h07, 1'b0, 10'h000);
        preq[7] = 0;
        word(1, 5'h08, 1'b0, 10'h001);
        word(1, 5'h08, 1'b0, 10'h000);
        tick(2);
        chk(32'(en[8]), 32'h0000_0000);
        arb = 4'h0a;
    endtask : t_rearb
    task automatic t_freeze();
        i_ce = 0;
        pulse(5'h03, 0);
        chk(32'(en[3]), 32'h0000_0000);
        i_ce = 1;
        tick(1);
    endtask : t_freeze
    task automatic t_pingpong();
        cfg(5'h06, 1'b0, dcc_pkg::DOUBLE_BUFFER_MODE, 10'h000);
        cfg(5'h06, 1'b1, dcc_pkg::DOUBLE_BUFFER_MODE, 10'h000);
        pulse(5'h06, 0);
        pulse(5'h06, 1);
        word(1, 5'h06, 1'b0, 10'h000);
        tick(3);
        chk(32'(en[6]), 32'h0000_0001);
        query(5'h06, 1'b0, dcc_pkg::TRANSFER_IDLE_MODE);
        pulse(5'h06, 1);
        word(1, 5'h06, 1'b1, 10'h000);
        tick(3);
        chk(32'(en[6]), 32'h0000_0000);
    endtask : t_pingpong
    task automatic t_swchan();
        clr = 1;
        tick(1);
        clr = 0;
        cfg(dcc_pkg::SOFTWARE_ONLY_CHANNEL, 1'b0, dcc_pkg::RUN_TO_COMPLETION_MODE, 10'h000);
        pulse(dcc_pkg::SOFTWARE_ONLY_CHANNEL, 0);
        pulse(dcc_pkg::SOFTWARE_ONLY_CHANNEL, 1);
        word(1, dcc_pkg::SOFTWARE_ONLY_CHANNEL, 1'b0, 10'h000);
        tick(2);
        chk({31'h0, FAR.done_sw_seen}, 32'h0000_0001);
        chk(FAR.done_periph_seen, 32'h0000_0000);
    endtask : t_swchan
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        #36 i_arst_n = 1;
        tick(1);
        chk(en, 32'h0000_0000);
        chk(32'(qm), 32'h0000_0000);
        t_modes();
        t_gate();
        t_sw_stall();
        t_hold();
        t_rearb();
        t_pingpong();
        t_swchan();
        t_freeze();
        stop_test();
    end
    initial begin
        #200000;
        miscompares++;
        stop_test();
    end
endmodule : dcc_channel_ctrl_bench
